// *** rtl/module_status_and_type_regs.sv ***
// Summary of operation
// RQ1 - Status write acknowledged, nothing stored.
// RQ2 - Pending operation flags in bits 15:8.
// RQ3 - One flag per pending operation, clears.
// RQ4 - Pending field zero when nothing pending.
// RQ5 - Bits 7:6 give current lock level.
// RQ6 - Reset lock level from nonvolatile, savable.
// RQ7 - Reserved status bit reads zero.
// RQ8 - Bit 4 shows module ready.
// RQ9 - Ready low in warm-up or bad config.
// RQ10 - Status read returns, then clears error.
// RQ11 - Code 0 success, 1 absent register.
// RQ12 - Codes 2 unwritable, 3 range error.
// RQ13 - Codes 4 pending, 5 initializing.
// RQ14 - Codes 6, 7 extended address errors.
// RQ15 - Codes 8 failure, 9 output active.
// RQ16 - Code 0x0A invalid configuration.
// RQ17 - Codes 0x0B-0x0E never produced.
// RQ18 - Host reads status after errors.
// RQ19 - Type read returns 9, sets pointer.
// RQ20 - Write echoes data; failures return zero.
// RQ21 - Type register write is execution error.
// RQ22 - Response status in bits 25:24.
`timescale 1ns/10ps
module module_status_and_type_regs
    import status_regs_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Command from the host packet decoder.
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_reg,
    input wire logic [15:0] cmd_data,
    // Outcome of commands served by other register blocks.
    input wire logic ext_claim,
    input wire logic ext_ok,
    input wire logic [1:0] ext_status,
    input wire logic [15:0] ext_data,
    input wire logic [3:0] ext_err_code,
    // Response toward the host packet encoder.
    output logic rsp_valid,
    output logic [31:0] rsp_frame,
    // Operation tracking.
    input wire logic [PENDING_W-1:0] op_start,
    input wire logic [PENDING_W-1:0] op_done,
    // Module condition.
    input wire logic init_active,
    input wire logic warmup_active,
    input wire logic config_invalid,
    input wire logic output_capable,
    input wire logic exec_fault,
    output logic module_ready_flag,
    // Lock level.
    input wire logic [1:0] nv_lock_default,
    input wire logic lock_load,
    input wire logic [1:0] lock_load_value,
    input wire logic save_defaults_operation,
    output logic [1:0] lock_level,
    output logic nv_lock_wr,
    output logic [1:0] nv_lock_wr_data,
    // Extended address access set-up.
    output logic ext_addr_setup,
    output logic [7:0] ext_addr_handle,
    output logic [15:0] ext_addr_length
);

    logic [PENDING_W-1:0] pending_q;
    logic [1:0] lock_q;
    logic boot_q;
    logic ready_q;
    logic ready_d;
    logic [3:0] err_q;
    logic [3:0] err_d;
    logic rsp_valid_q;
    logic [1:0] rsp_status_q;
    logic [1:0] rsp_status_d;
    logic [7:0] rsp_reg_q;
    logic [15:0] rsp_data_q;
    logic [15:0] rsp_data_d;
    logic nv_wr_q;
    logic [1:0] nv_data_q;
    logic setup_q;
    logic [7:0] handle_q;
    logic [15:0] length_q;
    logic setup_d;
    logic [15:0] status_word;
    cmd_kind_t kind;
    logic [3:0] cmd_err;

    // Classify a command by register number and direction.
    function automatic cmd_kind_t classify(input logic wr,
                                           input logic [7:0] num,
                                           input logic claimed);
        if (num == REG_STATUS_ERROR) begin
            classify = wr ? CMD_STATUS_WRITE : CMD_STATUS_READ;
        end else if (num == REG_DEVICE_TYPE) begin
            classify = wr ? CMD_TYPE_WRITE : CMD_TYPE_READ;
        end else if (claimed) begin
            classify = CMD_OTHER_CLAIMED;
        end else begin
            classify = CMD_ABSENT;
        end
    endfunction

    // Replace a code from the reserved range by a general failure.
    function automatic logic [3:0] legal_code(input logic [3:0] code);
        if (code >= ERR_RESERVED_FIRST && code <= ERR_RESERVED_LAST) begin
            legal_code = ERR_EXEC_FAILURE;
        end else begin
            legal_code = code;
        end
    endfunction

    // Refusal code shared by the commands that can be ignored.
    function automatic logic [3:0] gate_code(input logic init,
                                             input logic fault);
        if (init) begin
            // RQ13 - ignored while initializing.
            gate_code = ERR_INITIALIZING;
        end else if (fault) begin
            // RQ15 - general failure.
            gate_code = ERR_EXEC_FAILURE;
        end else begin
            gate_code = ERR_OK;
        end
    endfunction

    pending_flags u_pending (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .op_start(op_start),
        .op_done(op_done),
        .pending_q(pending_q)
    );

    // RQ6 - nonvolatile default load.
    // The default is caught one edge after reset release.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    // RQ5 - lock level hold.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_q <= LOCK_RESET;
        end else if (boot_q) begin
            lock_q <= nv_lock_default;
        end else if (lock_load) begin
            lock_q <= lock_load_value;
        end
    end

    // RQ6 - save defaults strobe.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_wr_q <= 1'b0;
        end else begin
            nv_wr_q <= save_defaults_operation;
        end
    end

    // RQ6 - saved lock level.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_data_q <= LOCK_RESET;
        end else if (save_defaults_operation) begin
            nv_data_q <= lock_q;
        end
    end

    // RQ9 - ready gating.
    always_comb begin
        ready_d = output_capable;
        if (init_active || warmup_active || config_invalid) begin
            ready_d = 1'b0;
        end
    end

    // RQ8 - ready flag.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
        end
    end

    // Assemble the live status word.
    always_comb begin
        status_word = DATA_ZERO;
        // RQ2 - pending field placement.
        // RQ4 - zero when idle.
        status_word[PENDING_MSB:PENDING_LSB] = pending_q;
        status_word[LOCK_MSB:LOCK_LSB] = lock_q;
        // RQ7 - reserved reads zero.
        status_word[RESERVED_BIT] = 1'b0;
        status_word[READY_BIT] = ready_q;
        status_word[ERR_MSB:ERR_LSB] = err_q;
    end

    assign kind = classify(cmd_write, cmd_reg, ext_claim);

    // Decide the outcome of the current command.
    always_comb begin
        cmd_err = ERR_OK;
        rsp_status_d = RSP_OK;
        rsp_data_d = DATA_ZERO;
        setup_d = 1'b0;
        case (kind)
            CMD_STATUS_READ: begin
                // RQ10 - return previous error.
                rsp_data_d = status_word;
            end
            CMD_STATUS_WRITE: begin
                cmd_err = gate_code(init_active, exec_fault);
                // RQ1 - echo, store nothing.
                // RQ20 - echo written data.
                rsp_data_d = cmd_data;
            end
            CMD_TYPE_READ: begin
                cmd_err = gate_code(init_active, exec_fault);
                // RQ19 - length and pointer.
                rsp_data_d = TYPE_STRING_LEN;
                rsp_status_d = RSP_EXT_ADDR;
                setup_d = 1'b1;
            end
            CMD_TYPE_WRITE: begin
                // RQ21 - write refused.
                // RQ12 - read-only register.
                cmd_err = ERR_REGISTER_UNWRITABLE;
            end
            CMD_OTHER_CLAIMED: begin
                // RQ17 - reserved codes filtered.
                // RQ14 - extended address codes.
                // RQ16 - passed through unchanged.
                if (ext_ok) begin
                    rsp_data_d = ext_data;
                    rsp_status_d = ext_status;
                end else if (ext_err_code == ERR_OK) begin
                    cmd_err = ERR_EXEC_FAILURE;
                end else begin
                    cmd_err = legal_code(ext_err_code);
                end
            end
            CMD_ABSENT: begin
                // RQ11 - absent register code.
                cmd_err = ERR_REGISTER_ABSENT;
            end
            default: begin
                cmd_err = ERR_EXEC_FAILURE;
            end
        endcase
        if (cmd_err != ERR_OK) begin
            // RQ20 - failures return zero.
            rsp_status_d = RSP_EXEC_ERROR;
            rsp_data_d = DATA_ZERO;
            setup_d = 1'b0;
        end
    end

    // Next value of the error field.
    always_comb begin
        err_d = err_q;
        if (cmd_valid) begin
            // RQ10 - cleared by successful read.
            // RQ11 - success code recorded.
            err_d = cmd_err;
        end
    end

    // Error field register.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            err_q <= ERR_RESET;
        end else begin
            err_q <= err_d;
        end
    end

    // Response strobe.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= cmd_valid;
        end
    end

    // Response register.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_status_q <= RSP_OK;
            rsp_reg_q <= REG_STATUS_ERROR;
            rsp_data_q <= DATA_ZERO;
        end else if (cmd_valid) begin
            rsp_status_q <= rsp_status_d;
            rsp_reg_q <= cmd_reg;
            rsp_data_q <= rsp_data_d;
        end
    end

    // Extended address set-up strobe.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            setup_q <= 1'b0;
        end else begin
            setup_q <= cmd_valid && setup_d;
        end
    end

    // Extended address set-up register.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            handle_q <= 8'h00;
            length_q <= DATA_ZERO;
        end else if (cmd_valid && setup_d) begin
            // RQ19 - point at type string.
            handle_q <= TYPE_STRING_HANDLE;
            length_q <= TYPE_STRING_LEN;
        end
    end

    // Response frame layout.
    always_comb begin
        rsp_frame = 32'h00000000;
        // RQ22 - status at 25:24.
        rsp_frame[RSP_STATUS_MSB:RSP_STATUS_LSB] = rsp_status_q;
        rsp_frame[RSP_REG_MSB:RSP_REG_LSB] = rsp_reg_q;
        rsp_frame[RSP_DATA_MSB:RSP_DATA_LSB] = rsp_data_q;
    end

    assign rsp_valid = rsp_valid_q;
    assign module_ready_flag = ready_q;
    assign lock_level = lock_q;
    assign nv_lock_wr = nv_wr_q;
    assign nv_lock_wr_data = nv_data_q;
    assign ext_addr_setup = setup_q;
    assign ext_addr_handle = handle_q;
    assign ext_addr_length = length_q;

endmodule // module_status_and_type_regs

// *** rtl/status_regs_pkg.sv ***
package status_regs_pkg;

    // Register numbers of the command interface.
    localparam logic [7:0] REG_STATUS_ERROR = 8'h00;
    localparam logic [7:0] REG_DEVICE_TYPE = 8'h01;

    // Field layout of the status and error register.
    localparam int PENDING_LSB = 8;
    localparam int PENDING_MSB = 15;
    localparam int PENDING_W = 8;
    localparam int LOCK_LSB = 6;
    localparam int LOCK_MSB = 7;
    localparam int RESERVED_BIT = 5;
    localparam int READY_BIT = 4;
    localparam int ERR_LSB = 0;
    localparam int ERR_MSB = 3;

    // Values after reset.
    localparam logic [7:0] PENDING_RESET = 8'h00;
    localparam logic [1:0] LOCK_RESET = 2'h0;
    localparam logic [3:0] ERR_RESET = 4'h0;
    localparam logic [15:0] DATA_ZERO = 16'h0000;

    // Byte length of the fixed type string, terminating null included.
    localparam logic [15:0] TYPE_STRING_LEN = 16'h0009;

    // Layout of the response frame.
    localparam int RSP_STATUS_LSB = 24;
    localparam int RSP_STATUS_MSB = 25;
    localparam int RSP_REG_LSB = 16;
    localparam int RSP_REG_MSB = 23;
    localparam int RSP_DATA_LSB = 0;
    localparam int RSP_DATA_MSB = 15;

    // Response status field values.
    localparam logic [1:0] RSP_OK = 2'h0;
    localparam logic [1:0] RSP_EXEC_ERROR = 2'h1;
    localparam logic [1:0] RSP_EXT_ADDR = 2'h2;

    // Error field codes.
    localparam logic [3:0] ERR_OK = 4'h0;
    localparam logic [3:0] ERR_REGISTER_ABSENT = 4'h1;
    localparam logic [3:0] ERR_REGISTER_UNWRITABLE = 4'h2;
    localparam logic [3:0] ERR_VALUE_RANGE = 4'h3;
    localparam logic [3:0] ERR_BUSY_PENDING = 4'h4;
    localparam logic [3:0] ERR_INITIALIZING = 4'h5;
    localparam logic [3:0] ERR_EXT_ADDR_INVALID = 4'h6;
    localparam logic [3:0] ERR_EXT_ADDR_READONLY = 4'h7;
    localparam logic [3:0] ERR_EXEC_FAILURE = 4'h8;
    localparam logic [3:0] ERR_OUTPUT_ACTIVE = 4'h9;
    localparam logic [3:0] ERR_BAD_CONFIGURATION = 4'ha;
    localparam logic [3:0] ERR_RESERVED_FIRST = 4'hb;
    localparam logic [3:0] ERR_RESERVED_LAST = 4'he;
    localparam logic [3:0] ERR_VENDOR_SPECIFIC = 4'hf;

    // Handle of the type string for the extended address logic.
    // The value is arbitrary.
    localparam logic [7:0] TYPE_STRING_HANDLE = 8'h5a;

    // Command kinds seen by the decoder.
    typedef enum logic [2:0] {
        CMD_STATUS_READ,
        CMD_STATUS_WRITE,
        CMD_TYPE_READ,
        CMD_TYPE_WRITE,
        CMD_OTHER_CLAIMED,
        CMD_ABSENT
    } cmd_kind_t;

endpackage

// *** rtl/pending_flags.sv ***
`timescale 1ns/10ps
module pending_flags
    import status_regs_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Operation events, one bit per flag position.
    input wire logic [PENDING_W-1:0] op_start,
    input wire logic [PENDING_W-1:0] op_done,
    // Flag state.
    output logic [PENDING_W-1:0] pending_q
);

    genvar i;
    generate
        for (i = 0; i < PENDING_W; i++) begin : g_flag
            // RQ3 - own flag slot.
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    pending_q[i] <= PENDING_RESET[i];
                end else if (op_start[i]) begin
                    pending_q[i] <= 1'b1;
                end else if (op_done[i]) begin
                    pending_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // pending_flags

// *** test/status_regs_sva.sv ***
`timescale 1ns/10ps
module status_regs_sva
    import status_regs_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Command and response.
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_reg,
    input wire logic [15:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_frame,
    // Module condition and lock.
    input wire logic init_active,
    input wire logic warmup_active,
    input wire logic config_invalid,
    input wire logic output_capable,
    input wire logic exec_fault,
    input wire logic module_ready_flag,
    input wire logic save_defaults_operation,
    input wire logic [1:0] lock_level,
    input wire logic nv_lock_wr,
    input wire logic [1:0] nv_lock_wr_data,
    input wire logic ext_addr_setup
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic rd0, wr0, rd1, wr1, calm, fit;
    assign rd0 = cmd_valid && !cmd_write && cmd_reg == REG_STATUS_ERROR;
    assign wr0 = cmd_valid && cmd_write && cmd_reg == REG_STATUS_ERROR;
    assign rd1 = cmd_valid && !cmd_write && cmd_reg == REG_DEVICE_TYPE;
    assign wr1 = cmd_valid && cmd_write && cmd_reg == REG_DEVICE_TYPE;
    assign calm = !init_active && !exec_fault;
    assign fit = output_capable && !warmup_active && !config_invalid
        && !init_active;
    AST_RSP_LATENCY: assert property (cmd_valid |=> rsp_valid)
        else $error("response missing");
    AST_RSP_ONLY: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("response without command");
    AST_FRAME_REG: assert property (cmd_valid |=>
        rsp_frame[23:16] == $past(cmd_reg) && rsp_frame[31:26] == 6'h00)
        else $error("frame register field wrong");
    AST_STATUS_ECHO: assert property (wr0 && calm |=>
        rsp_frame[25:0] == {RSP_OK, REG_STATUS_ERROR, $past(cmd_data)})
        else $error("status write not echoed");
    AST_RESERVED_ZERO: assert property (rd0 |=>
        rsp_frame[RESERVED_BIT] == 1'b0 && rsp_frame[25:24] == RSP_OK)
        else $error("reserved status bit set");
    AST_ERR_CLEAR: assert property (rd0 ##1 rd0 |=>
        rsp_frame[ERR_MSB:ERR_LSB] == ERR_OK)
        else $error("error field not cleared");
    AST_TYPE_READ: assert property (rd1 && calm |=> ext_addr_setup &&
        rsp_frame[25:0] == {RSP_EXT_ADDR, REG_DEVICE_TYPE, TYPE_STRING_LEN})
        else $error("type read answer wrong");
    AST_TYPE_WRITE: assert property (wr1 |=> !ext_addr_setup &&
        rsp_frame[25:24] == RSP_EXEC_ERROR && rsp_frame[15:0] == DATA_ZERO)
        else $error("type write not refused");
    AST_READY_LOW: assert property ((warmup_active || config_invalid)
        |=> !module_ready_flag)
        else $error("ready during warm-up");
    AST_READY_HIGH: assert property (fit [*2] |-> module_ready_flag)
        else $error("ready not raised");
    AST_SAVE_LOCK: assert property (save_defaults_operation |=>
        nv_lock_wr && nv_lock_wr_data == $past(lock_level))
        else $error("lock default not saved");
    COV_TYPE_READ: cover property (rd1 && calm);
    COV_BACK_TO_BACK: cover property (rd0 ##1 rd0);
    COV_SAVE: cover property (save_defaults_operation);
endmodule // status_regs_sva

bind module_status_and_type_regs status_regs_sva chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_frame(rsp_frame),
    .init_active(init_active), .warmup_active(warmup_active),
    .config_invalid(config_invalid), .output_capable(output_capable),
    .exec_fault(exec_fault), .module_ready_flag(module_ready_flag),
    .save_defaults_operation(save_defaults_operation),
    .lock_level(lock_level), .nv_lock_wr(nv_lock_wr),
    .nv_lock_wr_data(nv_lock_wr_data), .ext_addr_setup(ext_addr_setup));

// *** test/host_model.sv ***
`timescale 1ns/10ps
module host_model (
    // Clock.
    input wire logic sys_clk,
    // Command toward the block.
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_reg,
    output logic [15:0] cmd_data,
    // Response from the block.
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_frame
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_reg = 8'h00;
        cmd_data = 16'h0000;
    end
    // Sends one command n times back to back; f0 and f1 are the
    // first and last answers. Released reg and data lines show inverted values.
    task automatic send(input logic w, input logic [7:0] r,
            input logic [15:0] d, input int n,
            output logic [31:0] f0, output logic [31:0] f1);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_reg <= r;
        cmd_data <= d;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            if (i == n - 1) begin
                cmd_valid <= 1'b0;
                cmd_reg <= ~r;
                cmd_data <= ~d;
            end
            #1;
            f1 = (rsp_valid === 1'b1) ? rsp_frame : 32'hxxxxxxxx;
            if (i == 0) begin
                f0 = f1;
            end
        end
    endtask
    task automatic status(input int n, output logic [31:0] f0,
            output logic [31:0] f1);
        send(1'b0, 8'h00, 16'h0000, n, f0, f1);
    endtask
endmodule // host_model

// *** test/tb.sv ***
`timescale 1ns/10ps
module tb
    import status_regs_pkg::*;
;
    typedef struct packed {
        logic w; logic [7:0] r; logic [15:0] d; logic claim; logic init;
        logic fault; logic [1:0] st; logic [15:0] dat; logic [3:0] err;
    } row_t;
    logic sys_clk, rst_b, cmd_valid, cmd_write, ext_claim, ext_ok, rsp_valid;
    logic [7:0] cmd_reg, op_start, op_done;
    logic [15:0] cmd_data, ext_data;
    logic [1:0] ext_status, lock_load_value, lock_level;
    logic [1:0] nv_lock_default = 2'h2;
    logic [1:0] nv_lock_wr_data;
    logic [3:0] ext_err_code, exp_err;
    logic [31:0] rsp_frame, f0, f1;
    logic init_active, warmup_active, config_invalid, output_capable;
    logic exec_fault, module_ready_flag, lock_load, save_defaults_operation;
    logic nv_lock_wr;
    logic ext_addr_setup;
    logic [7:0] ext_addr_handle;
    logic [15:0] ext_addr_length;
    int n_errors = 0;
    int total_checks = 0;
    row_t rows [7] = '{
        '{1'b1, 8'h00, 16'hbeef, 1'b0, 1'b0, 1'b0, 2'h0, 16'hbeef, 4'h0},
        '{1'b0, 8'h01, 16'h0000, 1'b0, 1'b0, 1'b0, 2'h2, 16'h0009, 4'h0},
        '{1'b1, 8'h01, 16'h1111, 1'b0, 1'b0, 1'b0, 2'h1, 16'h0000, 4'h2},
        '{1'b0, 8'h30, 16'h0000, 1'b0, 1'b0, 1'b0, 2'h1, 16'h0000, 4'h1},
        '{1'b1, 8'h00, 16'h5555, 1'b0, 1'b1, 1'b0, 2'h1, 16'h0000, 4'h5},
        '{1'b0, 8'h01, 16'h0000, 1'b0, 1'b0, 1'b1, 2'h1, 16'h0000, 4'h8},
        '{1'b0, 8'h10, 16'h0000, 1'b1, 1'b0, 1'b0, 2'h0, 16'h1234, 4'h0}};
    module_status_and_type_regs dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_reg(cmd_reg),
        .cmd_data(cmd_data), .ext_claim(ext_claim), .ext_ok(ext_ok),
        .ext_status(ext_status), .ext_data(ext_data),
        .ext_err_code(ext_err_code), .rsp_valid(rsp_valid),
        .rsp_frame(rsp_frame), .op_start(op_start), .op_done(op_done),
        .init_active(init_active), .warmup_active(warmup_active),
        .config_invalid(config_invalid), .output_capable(output_capable),
        .exec_fault(exec_fault), .module_ready_flag(module_ready_flag),
        .nv_lock_default(nv_lock_default), .lock_load(lock_load),
        .lock_load_value(lock_load_value), .lock_level(lock_level),
        .save_defaults_operation(save_defaults_operation),
        .nv_lock_wr(nv_lock_wr), .nv_lock_wr_data(nv_lock_wr_data),
        .ext_addr_setup(ext_addr_setup), .ext_addr_handle(ext_addr_handle),
        .ext_addr_length(ext_addr_length));
    host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_frame(rsp_frame));
    function automatic logic [31:0] frame(input logic [1:0] s,
            input logic [7:0] r, input logic [15:0] d);
        return {6'h00, s, r, d};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic pulse(input logic [7:0] s, input logic [7:0] d,
            input logic [7:0] exp);
        @(posedge sys_clk);
        op_start <= s;
        op_done <= d;
        @(posedge sys_clk);
        op_start <= 8'h00;
        op_done <= 8'h00;
        host.status(1, f0, f1);
        check({24'h0, f1[15:8]}, {24'h0, exp});
    endtask
    task automatic cond(input logic w, input logic ci, input logic exp);
        @(posedge sys_clk);
        warmup_active <= w;
        config_invalid <= ci;
        repeat (2) @(posedge sys_clk);
        #1;
        check({31'h0, module_ready_flag}, {31'h0, exp});
    endtask
    // Nonvolatile store that keeps the saved lock level over a reset.
    always @(posedge sys_clk) begin
        if (nv_lock_wr) begin
            nv_lock_default <= nv_lock_wr_data;
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        {rst_b, ext_claim, ext_ok, ext_status, ext_err_code} = '0;
        {op_start, op_done, lock_load, lock_load_value} = '0;
        {init_active, warmup_active, config_invalid, exec_fault} = '0;
        {output_capable, save_defaults_operation} = '0;
        ext_data = 16'h1234;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            ext_claim <= rows[i].claim;
            ext_ok <= 1'b1;
            init_active <= rows[i].init;
            exec_fault <= rows[i].fault;
            host.send(rows[i].w, rows[i].r, rows[i].d, 1, f0, f1);
            check(f1, frame(rows[i].st, rows[i].r, rows[i].dat));
            check({31'h0, ext_addr_setup},
                {31'h0, rows[i].st == RSP_EXT_ADDR});
            @(posedge sys_clk);
            ext_claim <= 1'b0;
            host.status(1, f0, f1);
            check({28'h0, f1[3:0]}, {28'h0, rows[i].err});
        end
        check({8'h00, ext_addr_handle, ext_addr_length},
            {8'h00, TYPE_STRING_HANDLE, TYPE_STRING_LEN});
        for (int c = 0; c < 16; c++) begin
            @(posedge sys_clk);
            {ext_claim, ext_ok, ext_err_code} <= {2'b10, c[3:0]};
            host.send(1'b0, 8'h20, 16'h0000, 1, f0, f1);
            check(f1, frame(RSP_EXEC_ERROR, 8'h20, DATA_ZERO));
            @(posedge sys_clk);
            {ext_claim, ext_ok} <= 2'b01;
            host.status(1, f0, f1);
            exp_err = (c == 0 || (c > 10 && c < 15)) ? 4'h8 : c[3:0];
            check({28'h0, f1[3:0]}, {28'h0, exp_err});
        end
        host.send(1'b1, REG_DEVICE_TYPE, 16'h0001, 1, f0, f1);
        host.status(2, f0, f1);
        check({24'h0, f0[3:0], f1[3:0]},
            {24'h0, ERR_REGISTER_UNWRITABLE, ERR_OK});
        pulse(8'h88, 8'h00, 8'h88);
        pulse(8'h01, 8'h81, 8'h09);
        pulse(8'h00, 8'h09, 8'h00);
        @(posedge sys_clk);
        lock_load <= 1'b1;
        lock_load_value <= 2'h1;
        @(posedge sys_clk);
        lock_load <= 1'b0;
        save_defaults_operation <= 1'b1;
        @(posedge sys_clk);
        save_defaults_operation <= 1'b0;
        #1;
        check({29'h0, nv_lock_wr, nv_lock_wr_data}, 32'h5);
        check({30'h0, lock_level}, 32'h1);
        host.status(1, f0, f1);
        check({30'h0, f1[7:6]}, 32'h1);
        @(posedge sys_clk);
        output_capable <= 1'b1;
        cond(1'b0, 1'b0, 1'b1);
        cond(1'b1, 1'b0, 1'b0);
        cond(1'b0, 1'b1, 1'b0);
        cond(1'b0, 1'b0, 1'b1);
        host.status(1, f0, f1);
        check({31'h0, f1[READY_BIT]}, 32'h1);
        @(posedge sys_clk);
        output_capable <= 1'b0;
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        host.status(1, f0, f1);
        check(f1, frame(RSP_OK, REG_STATUS_ERROR, 16'h0040));
        finish_test();
    end
endmodule // tb
